// >>> dv/ext_programmer_model.sv
// External programming tool model: issues requests and owns the lock bits
// it has burned into the second configuration byte.
// Assumes the bench pulses issue at rising edges; one request per issue cycle.
`timescale 1ns/1ps
module ext_programmer_model #(
    parameter logic [5:0] SPARE_BITS = 6'h15
) (
    // Clock
    input  wire logic              core_clk,
    // Bench commands
    input  wire logic              issue,
    input  wire cfg_pkg::ext_cmd_t cmd_in,
    input  wire logic [1:0]        lock_req,
    // Device side
    output logic                   ext_req,
    output cfg_pkg::ext_cmd_t      ext_cmd,
    output logic [7:0]             nv_byte_two
);
    logic [1:0] next_locks;
    logic [4:0] idle_pat = 5'h0a;

    always_comb begin
        next_locks = lock_req;
        if (lock_req == 2'h2) begin
            next_locks = 2'h3;
        end
    end

    // Locks reach the cells on every clock edge, during traffic too; a request of 2'h2 is burned as 2'h3
    always_ff @(posedge core_clk) begin
        idle_pat    <= ~idle_pat;
        ext_req     <= issue;
        ext_cmd     <= issue ? cmd_in : cfg_pkg::ext_cmd_t'(idle_pat);
        nv_byte_two <= {next_locks, SPARE_BITS};
    end
endmodule // ext_programmer_model

// >>> dv/test_config_byte_decoder.sv
// Self-checking bench for the configuration byte decoder.
// Assumes default byte addresses and the programmer model as the far side.
`timescale 1ns/1ps
module test_config_byte_decoder;
    localparam logic [15:0] ONE_ADDR = 16'hfffe;
    localparam logic [15:0] TWO_ADDR = 16'hffff;
    localparam logic [5:0]  SPARE    = 6'h15;

    logic                 core_clk       = 1'b0;
    logic                 rst_n          = 1'b0;
    logic [7:0]           nv_byte_one    = 8'h00;
    logic [1:0]           lock_req       = 2'h3;
    logic                 prog_issue     = 1'b0;
    cfg_pkg::ext_cmd_t    prog_cmd       = '0;
    logic                 cpu_rd_req     = 1'b0;
    logic [15:0]          cpu_rd_addr    = 16'h0000;
    logic                 reset_pin_in_n = 1'b1;
    logic [7:0]           nv_byte_two;
    logic                 ext_req;
    cfg_pkg::ext_cmd_t    ext_cmd;
    logic                 cpu_rd_valid;
    logic                 cpu_rd_hit;
    logic [7:0]           cpu_rd_data;
    logic                 ext_ack;
    logic                 ext_grant;
    logic                 ext_deny;
    logic [7:0]           ext_cfg_data;
    logic                 pin_reset_req;
    logic                 shared_pin_input;
    logic                 cfg_loaded;
    cfg_pkg::cfg_fields_t cfg_fields;
    logic                 osc_cfg_reserved;
    logic                 lock_combo_invalid;
    logic [15:0]          cpu_q[$];
    logic [15:0]          ext_q[$];
    logic [31:0]          lfsr = 32'h32d078c8;
    int                   fails = 0;
    int                   checked = 0;

    always #50 core_clk = ~core_clk;

    config_byte_decoder dut (.core_clk(core_clk), .rst_n(rst_n), .nv_byte_one(nv_byte_one),
        .nv_byte_two(nv_byte_two), .cpu_rd_req(cpu_rd_req), .cpu_rd_addr(cpu_rd_addr),
        .cpu_rd_valid(cpu_rd_valid), .cpu_rd_hit(cpu_rd_hit), .cpu_rd_data(cpu_rd_data),
        .ext_req(ext_req), .ext_cmd(ext_cmd), .ext_ack(ext_ack), .ext_grant(ext_grant),
        .ext_deny(ext_deny), .ext_cfg_data(ext_cfg_data), .reset_pin_in_n(reset_pin_in_n),
        .pin_reset_req(pin_reset_req), .shared_pin_input(shared_pin_input), .cfg_loaded(cfg_loaded),
        .cfg_fields(cfg_fields), .osc_cfg_reserved(osc_cfg_reserved),
        .lock_combo_invalid(lock_combo_invalid));

    ext_programmer_model #(.SPARE_BITS(SPARE)) prog (.core_clk(core_clk), .issue(prog_issue),
        .cmd_in(prog_cmd), .lock_req(lock_req), .ext_req(ext_req), .ext_cmd(ext_cmd),
        .nv_byte_two(nv_byte_two));

    function automatic logic [31:0] lfsr_next(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction

    task automatic compare(input logic [15:0] got, input logic [15:0] exp);
        checked++;
        if (got !== exp) begin
            fails++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic give_verdict();
        $display("comparisons %0d mismatches %0d", checked, fails);
        if (fails == 0 && checked > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    // Results are matched in arrival order against the driver's notes
    always @(negedge core_clk) begin
        if (cpu_rd_valid === 1'b1) begin
            compare({7'h00, cpu_rd_hit, cpu_rd_data}, cpu_q.size() > 0 ? cpu_q.pop_front() : 16'hffff);
        end
        if (ext_ack === 1'b1) begin
            compare({6'h00, ext_grant, ext_deny, ext_cfg_data}, ext_q.size() > 0 ? ext_q.pop_front() : 16'hffff);
        end
    end

    task automatic check_fields(input logic [7:0] b1);
        compare({8'h00, cfg_loaded, cfg_fields, osc_cfg_reserved, lock_combo_invalid},
                {8'h00, 1'b1, b1[6], b1[5], b1[4], b1[1:0], b1[1:0] == 2'h2, 1'b0});
    endtask

    task automatic cpu_read(input logic [15:0] addr, input logic [15:0] exp);
        cpu_rd_req  <= 1'b1;
        cpu_rd_addr <= addr;
        cpu_q.push_back(exp);
        @(posedge core_clk);
    endtask

    task automatic ext_send(input cfg_pkg::ext_cmd_t cmd, input logic [15:0] exp);
        prog_issue <= 1'b1;
        prog_cmd   <= cmd;
        ext_q.push_back(exp);
        @(posedge core_clk);
    endtask

    initial begin
        #(100 * 3000);
        fails++;
        give_verdict();
    end

    initial begin
        logic [7:0] b1;
        logic [7:0] b2;
        logic [1:0] locks;
        logic       allow;
        logic       sel;
        logic [7:0] rdata;
        for (int i = 0; i < 4; i++) begin
            lfsr  = lfsr_next(lfsr);
            locks = (i == 1) ? 2'h1 : (i == 2) ? 2'h0 : 2'h3;
            // Pin, level and brownout bits follow the test number so both values appear
            b1    = {lfsr[7], i[0], i[1], i[0] ^ i[1], lfsr[3:2], i[1:0]};
            b2    = {locks, SPARE};
            @(posedge core_clk);
            rst_n       <= 1'b0;
            nv_byte_one <= b1;
            lock_req    <= locks;
            repeat (4) @(posedge core_clk);
            rst_n <= 1'b1;
            repeat (2) @(posedge core_clk);
            @(negedge core_clk);
            check_fields(b1);
            @(posedge core_clk);
            // Cells rewritten while running must not leak through
            nv_byte_one <= ~b1;
            lock_req    <= 2'h3;
            cpu_read(ONE_ADDR, {8'h01, b1});
            cpu_read(TWO_ADDR, {8'h01, b2});
            cpu_read({1'b0, lfsr[22:8]}, 16'h0000);
            cpu_rd_req  <= 1'b0;
            cpu_rd_addr <= lfsr[31:16];
            for (int op = 0; op < 4; op++) begin
                for (int area = 0; area < 3; area++) begin
                    lfsr  = lfsr_next(lfsr);
                    sel   = lfsr[0];
                    allow = (op < 3) && ((area == 0) ? locks[1] : (area == 1) ? locks[0] : &locks);
                    rdata = (allow && op == 2 && area == 2) ? (sel ? b2 : b1) : 8'h00;
                    ext_send(cfg_pkg::ext_cmd_t'({op[1:0], area[1:0], sel}), {6'h00, allow, ~allow, rdata});
                end
            end
            prog_issue <= 1'b0;
            repeat (3) @(posedge core_clk);
            reset_pin_in_n <= 1'b0;
            @(posedge core_clk);
            @(negedge core_clk);
            compare({14'h0000, pin_reset_req, shared_pin_input}, {14'h0000, ~b1[6], ~b1[6]});
            check_fields(b1);
            @(posedge core_clk);
            reset_pin_in_n <= 1'b1;
            $display("test %0d done", i);
        end
        repeat (3) @(posedge core_clk);
        compare(16'(cpu_q.size() + ext_q.size()), 16'h0000);
        give_verdict();
    end
endmodule // test_config_byte_decoder

// >>> rtl/cfg_capture.sv
// Capture of the two configuration bytes once after reset release.
// Assumes the nonvolatile cells are stable by the first edge after release.
`timescale 1ns/1ps
module cfg_capture (
    // Clock and reset
    input  wire logic                    core_clk,
    input  wire logic                    rst_n,
    // Nonvolatile cells
    input  wire logic [cfg_pkg::CFG_W-1:0] nv_byte_one,
    input  wire logic [cfg_pkg::CFG_W-1:0] nv_byte_two,
    // Held copies
    output logic      [cfg_pkg::CFG_W-1:0] byte_one,
    output logic      [cfg_pkg::CFG_W-1:0] byte_two,
    output logic                           loaded
);

    typedef enum logic {
        CAP_WAIT,
        CAP_HOLD
    } cap_state_t;

    cap_state_t                  state;
    cap_state_t                  next_state;
    logic [cfg_pkg::CFG_W-1:0]   next_byte_one;
    logic [cfg_pkg::CFG_W-1:0]   next_byte_two;
    logic                        next_loaded;

    // Strap style capture: taken by a clocked edge after release, never by reset
    always_comb begin
        next_state    = state;
        next_byte_one = byte_one;
        next_byte_two = byte_two;
        next_loaded   = loaded;
        unique case (state)
            CAP_WAIT: begin
                next_byte_one = nv_byte_one;
                next_byte_two = nv_byte_two;
                next_loaded   = 1'b1;
                next_state    = CAP_HOLD;
            end
            CAP_HOLD: begin
                // Frozen until the next reset, whatever the cells do
            end
        endcase
    end

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            state    <= CAP_WAIT;
            byte_one <= cfg_pkg::CFG_ONE_PRELOAD;
            byte_two <= cfg_pkg::CFG_TWO_PRELOAD;
            loaded   <= 1'b0;
        end else begin
            state    <= next_state;
            byte_one <= next_byte_one;
            byte_two <= next_byte_two;
            loaded   <= next_loaded;
        end
    end

endmodule // cfg_capture

// >>> rtl/cfg_pkg.sv
// Constants and carrier types for the configuration byte decoder.
// Assumes both configuration bytes are eight bits wide and fixed after power-up.
package cfg_pkg;

    localparam int CFG_W = 8;

    // Field positions in the first configuration byte
    localparam int CFG_PIN_DIS_BIT  = 6;
    localparam int CFG_PRL_BIT      = 5;
    localparam int CFG_BROWNOUT_BIT = 4;
    localparam int CFG_OSC_HI_BIT   = 1;
    localparam int CFG_OSC_LO_BIT   = 0;

    // Field positions in the second configuration byte
    localparam int CFG_CODE_LOCK_BIT = 7;
    localparam int CFG_DATA_LOCK_BIT = 6;

    // Held values before the cells are captured; locked is the safe side
    localparam logic [CFG_W-1:0] CFG_ONE_PRELOAD = 8'h00;
    localparam logic [CFG_W-1:0] CFG_TWO_PRELOAD = 8'h00;
    localparam logic [CFG_W-1:0] CFG_READ_NONE   = 8'h00;

    typedef enum logic [1:0] {
        OSC_CRYSTAL  = 2'h0,
        OSC_INT_RC   = 2'h1,
        OSC_RESERVED = 2'h2,
        OSC_EXTERNAL = 2'h3
    } osc_src_t;

    typedef enum logic [1:0] {
        EXT_ERASE   = 2'h0,
        EXT_PROGRAM = 2'h1,
        EXT_READ    = 2'h2
    } ext_op_t;

    typedef enum logic [1:0] {
        AREA_CODE   = 2'h0,
        AREA_DATA   = 2'h1,
        AREA_CONFIG = 2'h2
    } ext_area_t;

    typedef struct packed {
        ext_op_t   op;
        ext_area_t area;
        logic      sel_two;
    } ext_cmd_t;

    typedef struct packed {
        logic     reset_pin_disable;
        logic     port_reset_level;
        logic     brownout_threshold_sel;
        osc_src_t osc_sel;
    } cfg_fields_t;

endpackage

// >>> rtl/config_byte_decoder.sv
// Configuration byte decoder: holds the two power-up bytes, decodes the
// settings, answers CPU program-memory reads and gates the external programmer.
// Assumes all inputs are synchronous to core_clk and the cells settle before reset release.
`timescale 1ns/1ps

// Function
// - Capture both bytes once after reset; settings never change while running.
// - CPU program-memory reads at the two byte addresses return the held bytes.
// - Byte one bit 6 low keeps pin reset; high frees the pin as input.
// - Byte one bit 5 gives the port reset level, low or high.
// - Byte one bit 4 selects brownout threshold, 3.8V at 0, 2.5 V at 1.
// - Byte one bits 1:0 select crystal, internal RC, reserved or external clock.
// - Code lock low blocks external access to code flash and configuration bytes.
// - Data lock low blocks external access to data flash and configuration bytes.
// - Both locks high allow erase, program and read of both areas.
// - Code locked, data open: external reads of the code area are refused.
// - Both locked: external reads of code and data areas are refused.
module config_byte_decoder #(
    parameter int                ADDR_W       = 16,
    parameter logic [ADDR_W-1:0] CFG_ONE_ADDR = 16'hfffe,
    parameter logic [ADDR_W-1:0] CFG_TWO_ADDR = 16'hffff
) (
    // Clock and reset
    input  wire logic                          core_clk,
    input  wire logic                          rst_n,
    // Nonvolatile configuration cells
    input  wire logic [cfg_pkg::CFG_W-1:0]     nv_byte_one,
    input  wire logic [cfg_pkg::CFG_W-1:0]     nv_byte_two,
    // CPU program-memory read
    input  wire logic                          cpu_rd_req,
    input  wire logic [ADDR_W-1:0]             cpu_rd_addr,
    output logic                               cpu_rd_valid,
    output logic                               cpu_rd_hit,
    output logic      [cfg_pkg::CFG_W-1:0]     cpu_rd_data,
    // External programmer requests
    input  wire logic                          ext_req,
    input  wire cfg_pkg::ext_cmd_t             ext_cmd,
    output logic                               ext_ack,
    output logic                               ext_grant,
    output logic                               ext_deny,
    output logic      [cfg_pkg::CFG_W-1:0]     ext_cfg_data,
    // Shared reset pin
    input  wire logic                          reset_pin_in_n,
    output logic                               pin_reset_req,
    output logic                               shared_pin_input,
    // Decoded settings
    output logic                               cfg_loaded,
    output cfg_pkg::cfg_fields_t               cfg_fields,
    output logic                               osc_cfg_reserved,
    output logic                               lock_combo_invalid
);

    if (ADDR_W < 2) begin : g_bad_width
        $error("config_byte_decoder: ADDR_W too small");
    end
    if (CFG_ONE_ADDR == CFG_TWO_ADDR) begin : g_bad_addr
        $error("config_byte_decoder: byte addresses must differ");
    end

    logic [cfg_pkg::CFG_W-1:0] byte_one;
    logic [cfg_pkg::CFG_W-1:0] byte_two;
    logic                      cap_loaded;
    logic                      ext_allow;
    logic                      code_lock;
    logic                      data_lock;

    logic                      next_cpu_rd_valid;
    logic                      next_cpu_rd_hit;
    logic [cfg_pkg::CFG_W-1:0] next_cpu_rd_data;
    logic                      next_ext_ack;
    logic                      next_ext_grant;
    logic                      next_ext_deny;
    logic [cfg_pkg::CFG_W-1:0] next_ext_cfg_data;
    logic                      next_pin_reset_req;
    logic                      next_shared_pin_input;
    logic                      next_cfg_loaded;
    cfg_pkg::cfg_fields_t      next_cfg_fields;
    logic                      next_osc_cfg_reserved;
    logic                      next_lock_combo_invalid;

    cfg_capture u_capture (
        .core_clk    (core_clk),
        .rst_n       (rst_n),
        .nv_byte_one (nv_byte_one),
        .nv_byte_two (nv_byte_two),
        .byte_one    (byte_one),
        .byte_two    (byte_two),
        .loaded      (cap_loaded)
    );

    assign code_lock = byte_two[cfg_pkg::CFG_CODE_LOCK_BIT];
    assign data_lock = byte_two[cfg_pkg::CFG_DATA_LOCK_BIT];

    ext_access_gate u_gate (
        .loaded    (cap_loaded),
        .code_lock (code_lock),
        .data_lock (data_lock),
        .cmd       (ext_cmd),
        .allow     (ext_allow)
    );

    // Settings decode; the held bytes never move, so neither do these
    always_comb begin
        next_cfg_loaded                        = cap_loaded;
        next_cfg_fields.reset_pin_disable      = byte_one[cfg_pkg::CFG_PIN_DIS_BIT];
        next_cfg_fields.port_reset_level       = byte_one[cfg_pkg::CFG_PRL_BIT];
        next_cfg_fields.brownout_threshold_sel = byte_one[cfg_pkg::CFG_BROWNOUT_BIT];
        next_cfg_fields.osc_sel                = cfg_pkg::osc_src_t'({byte_one[cfg_pkg::CFG_OSC_HI_BIT],
                                                                    byte_one[cfg_pkg::CFG_OSC_LO_BIT]});
        // Reserved clock code is flagged; the clock unit decides what to do with it
        next_osc_cfg_reserved   = cap_loaded && (next_cfg_fields.osc_sel == cfg_pkg::OSC_RESERVED);
        // Unsupported lock pair; nothing here repairs it
        next_lock_combo_invalid = cap_loaded && code_lock && !data_lock;
    end

    // Shared pin: reset only while enabled; pin reads high while it is a reset input
    always_comb begin
        next_pin_reset_req    = 1'b0;
        next_shared_pin_input = 1'b1;
        if (cfg_loaded) begin
            if (cfg_fields.reset_pin_disable) begin
                next_shared_pin_input = reset_pin_in_n;
            end else begin
                next_pin_reset_req = !reset_pin_in_n;
            end
        end
    end

    // CPU reads ignore the locks; only the outside world is kept out
    always_comb begin
        next_cpu_rd_valid = cpu_rd_req;
        next_cpu_rd_hit   = 1'b0;
        next_cpu_rd_data  = cfg_pkg::CFG_READ_NONE;
        if (cpu_rd_req) begin
            if (cpu_rd_addr == CFG_ONE_ADDR) begin
                next_cpu_rd_hit  = 1'b1;
                next_cpu_rd_data = byte_one;
            end else if (cpu_rd_addr == CFG_TWO_ADDR) begin
                next_cpu_rd_hit  = 1'b1;
                next_cpu_rd_data = byte_two;
            end
        end
    end

    // Programmer verdict, one cycle after the request
    always_comb begin
        next_ext_ack      = ext_req;
        next_ext_grant    = ext_req && ext_allow;
        next_ext_deny     = ext_req && !ext_allow;
        next_ext_cfg_data = cfg_pkg::CFG_READ_NONE;
        if (ext_req && ext_allow && ext_cmd.op == cfg_pkg::EXT_READ
            && ext_cmd.area == cfg_pkg::AREA_CONFIG) begin
            next_ext_cfg_data = ext_cmd.sel_two ? byte_two : byte_one;
        end
    end

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            cfg_loaded         <= 1'b0;
            cfg_fields         <= '0;
            osc_cfg_reserved   <= 1'b0;
            lock_combo_invalid <= 1'b0;
            pin_reset_req      <= 1'b0;
            shared_pin_input   <= 1'b1;
            cpu_rd_valid       <= 1'b0;
            cpu_rd_hit         <= 1'b0;
            cpu_rd_data        <= cfg_pkg::CFG_READ_NONE;
            ext_ack            <= 1'b0;
            ext_grant          <= 1'b0;
            ext_deny           <= 1'b0;
            ext_cfg_data       <= cfg_pkg::CFG_READ_NONE;
        end else begin
            cfg_loaded         <= next_cfg_loaded;
            cfg_fields         <= next_cfg_fields;
            osc_cfg_reserved   <= next_osc_cfg_reserved;
            lock_combo_invalid <= next_lock_combo_invalid;
            pin_reset_req      <= next_pin_reset_req;
            shared_pin_input   <= next_shared_pin_input;
            cpu_rd_valid       <= next_cpu_rd_valid;
            cpu_rd_hit         <= next_cpu_rd_hit;
            cpu_rd_data        <= next_cpu_rd_data;
            ext_ack            <= next_ext_ack;
            ext_grant          <= next_ext_grant;
            ext_deny           <= next_ext_deny;
            ext_cfg_data       <= next_ext_cfg_data;
        end
    end

    default clocking dcb @(posedge core_clk); endclocking
    default disable iff (!rst_n);

    AST_CFG_FROZEN: assert property (
        cfg_loaded && $past(cfg_loaded) |-> $stable(cfg_fields) && $stable(byte_two))
        else $error("settings changed after capture");

    AST_CPU_READ_ONE: assert property (
        cpu_rd_req && cpu_rd_addr == CFG_ONE_ADDR
        |=> cpu_rd_valid && cpu_rd_hit && cpu_rd_data == $past(byte_one))
        else $error("cpu read of first byte wrong");

    AST_CPU_READ_TWO: assert property (
        cpu_rd_req && cpu_rd_addr == CFG_TWO_ADDR
        |=> cpu_rd_valid && cpu_rd_hit && cpu_rd_data == $past(byte_two))
        else $error("cpu read of second byte wrong");

    AST_RESET_PIN_KEPT: assert property (
        cfg_loaded && !cfg_fields.reset_pin_disable && !reset_pin_in_n
        |=> pin_reset_req && shared_pin_input)
        else $error("pin reset not raised");

    AST_RESET_PIN_FREED: assert property (
        cfg_loaded && cfg_fields.reset_pin_disable
        |=> !pin_reset_req && shared_pin_input == $past(reset_pin_in_n))
        else $error("disabled pin still acts as reset");

    AST_PORT_LEVEL: assert property (
        cfg_loaded |-> cfg_fields.port_reset_level == byte_one[cfg_pkg::CFG_PRL_BIT])
        else $error("port reset level mismatch");

    AST_BROWNOUT_SEL: assert property (
        cfg_loaded |-> cfg_fields.brownout_threshold_sel == byte_one[cfg_pkg::CFG_BROWNOUT_BIT])
        else $error("brownout select mismatch");

    AST_OSC_SEL: assert property (
        cfg_loaded |-> cfg_fields.osc_sel[1] == byte_one[cfg_pkg::CFG_OSC_HI_BIT]
        && cfg_fields.osc_sel[0] == byte_one[cfg_pkg::CFG_OSC_LO_BIT]
        && osc_cfg_reserved == (cfg_fields.osc_sel == cfg_pkg::OSC_RESERVED))
        else $error("oscillator select mismatch");

    AST_CODE_LOCK: assert property (
        ext_req && !code_lock && ext_cmd.area != cfg_pkg::AREA_DATA
        |=> ext_ack && ext_deny && !ext_grant && ext_cfg_data == cfg_pkg::CFG_READ_NONE)
        else $error("code lock let access through");

    AST_DATA_LOCK: assert property (
        ext_req && !data_lock && ext_cmd.area != cfg_pkg::AREA_CODE
        |=> ext_ack && ext_deny && !ext_grant)
        else $error("data lock let access through");

    AST_UNLOCKED_OPEN: assert property (
        ext_req && cap_loaded && code_lock && data_lock && ext_cmd.op != 2'h3
        && ext_cmd.area != 2'h3 |=> ext_grant && !ext_deny)
        else $error("unlocked part refused access");

    AST_CODE_READ_REFUSED: assert property (
        ext_req && !code_lock && data_lock && ext_cmd.op == cfg_pkg::EXT_READ
        && ext_cmd.area == cfg_pkg::AREA_CODE |=> ext_deny && !ext_grant)
        else $error("locked code area was read");

    AST_ALL_READ_REFUSED: assert property (
        ext_req && !code_lock && !data_lock && ext_cmd.op == cfg_pkg::EXT_READ
        |=> ext_deny && !ext_grant)
        else $error("fully locked part was read");

    AST_LOADED_STAYS: assert property (
        cfg_loaded |=> cfg_loaded)
        else $error("settings dropped while running");

    AST_HELD_BYTES: assert property (
        cap_loaded |=> $stable(byte_one) && $stable(byte_two))
        else $error("held bytes moved after capture");

    AST_CPU_MISS: assert property (
        cpu_rd_req && cpu_rd_addr != CFG_ONE_ADDR && cpu_rd_addr != CFG_TWO_ADDR
        |=> cpu_rd_valid && !cpu_rd_hit && cpu_rd_data == cfg_pkg::CFG_READ_NONE)
        else $error("cpu read of other address hit");

    AST_CPU_QUIET: assert property (
        !cpu_rd_req |=> !cpu_rd_valid && !cpu_rd_hit)
        else $error("cpu answer without request");

    AST_PIN_IDLE: assert property (
        !cfg_loaded |-> !pin_reset_req && shared_pin_input)
        else $error("shared pin active before settings");

    AST_EXT_ONE_VERDICT: assert property (
        ext_req |=> ext_ack && (ext_grant != ext_deny))
        else $error("programmer got no single verdict");

    AST_EXT_QUIET: assert property (
        !ext_req |=> !ext_ack && !ext_grant && !ext_deny
        && ext_cfg_data == cfg_pkg::CFG_READ_NONE)
        else $error("programmer answer without request");

    AST_CFG_READ_DATA: assert property (
        ext_req && cap_loaded && code_lock && data_lock && ext_cmd.op == cfg_pkg::EXT_READ
        && ext_cmd.area == cfg_pkg::AREA_CONFIG
        |=> ext_cfg_data == ($past(ext_cmd.sel_two) ? byte_two : byte_one))
        else $error("config read returned wrong byte");

    AST_LOCKED_CFG_DATA: assert property (
        ext_req && !(code_lock && data_lock) |=> ext_cfg_data == cfg_pkg::CFG_READ_NONE)
        else $error("locked part leaked a config byte");

    AST_DATA_OPEN_ALONE: assert property (
        ext_req && cap_loaded && !code_lock && data_lock && ext_cmd.area == cfg_pkg::AREA_DATA
        && ext_cmd.op inside {cfg_pkg::EXT_ERASE, cfg_pkg::EXT_PROGRAM, cfg_pkg::EXT_READ}
        |=> ext_grant && !ext_deny)
        else $error("open data area refused");

    AST_COMBO_FLAG: assert property (
        cfg_loaded |-> lock_combo_invalid == (code_lock && !data_lock))
        else $error("lock pair flag mismatch");

endmodule // config_byte_decoder

// >>> rtl/ext_access_gate.sv
// Combinational lock decision for requests from the external programmer.
// Assumes lock bits come from the held second configuration byte.
`timescale 1ns/1ps
module ext_access_gate (
    // Held state
    input  wire logic              loaded,
    input  wire logic              code_lock,
    input  wire logic              data_lock,
    // Request under test
    input  wire cfg_pkg::ext_cmd_t cmd,
    // Verdict
    output logic                   allow
);

    logic op_ok;

    always_comb begin
        op_ok = 1'b0;
        allow = 1'b0;
        unique case (cmd.op)
            cfg_pkg::EXT_ERASE,
            cfg_pkg::EXT_PROGRAM,
            cfg_pkg::EXT_READ: op_ok = 1'b1;
            default:           op_ok = 1'b0;
        endcase
        // Nothing passes before capture, so a locked part never leaks early
        if (loaded && op_ok) begin
            unique case (cmd.area)
                cfg_pkg::AREA_CODE:   allow = code_lock;
                cfg_pkg::AREA_DATA:   allow = data_lock;
                cfg_pkg::AREA_CONFIG: allow = code_lock && data_lock;
                default:              allow = 1'b0;
            endcase
        end
    end

endmodule // ext_access_gate
